// ===== hdl/sdram_bank_fsm.sv
// per-bank state tracker with timers for activate, recovery and precharge
// assumes commands already decoded and gated by the top
module sdram_bank_fsm
   import sdram_ctl_pkg::*;
(
   input  wire logic  i_core_clk,
   input  wire logic  i_resetn,
   input  wire logic  i_tick,
   input  wire logic  i_act,
   input  wire logic  i_pre,
   input  wire logic  i_burst_start,
   input  wire logic  i_burst_ap,
   input  wire logic  i_burst_end,
   input  wire logic  i_burst_was_write,
   output bank_state_t o_state,
   output logic       o_idle
);
   bank_state_t            state_reg, state_next;
   logic [BANK_CNT_W-1:0]  cnt_reg, cnt_next;
   logic                   ap_reg, ap_next;
   wire                    cnt_done = (cnt_reg <= CNT_ONE);

   assign o_state = state_reg;
   assign o_idle  = (state_reg == BK_IDLE);

   always_comb begin
      state_next = state_reg;
      cnt_next   = (cnt_reg != '0) ? cnt_reg - CNT_ONE : cnt_reg;
      ap_next    = ap_reg;
      if (i_tick) begin
         case (state_reg)
            BK_IDLE: if (i_act) begin
               state_next = BK_ACTIVATING;
               cnt_next   = RCD_CYC;
            end
            BK_ACTIVATING: if (cnt_done) state_next = BK_ACTIVE;
            BK_ACTIVE, BK_BURST: begin
               if (i_pre) begin
                  state_next = BK_PRECHARGE;
                  cnt_next   = RP_CYC;
               end else if (i_burst_start) begin
                  state_next = BK_BURST;
                  ap_next    = i_burst_ap;
               end else if (state_reg == BK_BURST && i_burst_end) begin
                  // concurrent auto precharge: write waits recovery, read goes now
                  if (ap_reg && i_burst_was_write) begin
                     state_next = BK_RECOVER;
                     cnt_next   = WR_CYC;
                  end else if (ap_reg) begin
                     state_next = BK_PRECHARGE;
                     cnt_next   = RP_CYC;
                  end else begin
                     state_next = BK_ACTIVE;
                  end
               end
            end
            BK_RECOVER: if (cnt_done) begin
               state_next = BK_PRECHARGE;
               cnt_next   = RP_CYC;
            end
            BK_PRECHARGE: if (cnt_done) state_next = BK_IDLE;
            default: state_next = BK_IDLE;
         endcase
      end else begin
         cnt_next = cnt_reg;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         state_reg <= BK_IDLE;
         cnt_reg   <= '0;
         ap_reg    <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         ap_reg    <= ap_next;
      end
   end
endmodule // sdram_bank_fsm

// ===== hdl/sdram_bank_state_cke_control.sv
// device-side command, bank state and clock-enable control
// assumes pins synchronous to i_core_clk; array sits behind the write fifo
module sdram_bank_state_cke_control
   import sdram_ctl_pkg::*;
(
   input  wire logic                   i_core_clk,
   input  wire logic                   i_resetn,
   input  wire logic                   i_cke,
   input  sdram_ctl_pkg::cmd_pins_t    i_cmd,
   input  wire logic [1:0]             i_dqm,
   input  wire logic [DQ_W-1:0]        i_dq,
   input  wire logic [CL_W-1:0]        i_cas_latency,
   input  wire logic [BL_W-1:0]        i_burst_len,
   input  wire logic [DQ_W-1:0]        i_array_rdata,
   input  wire logic                   i_array_wr_ready,
   output logic [DQ_W-1:0]             o_dq,
   output logic                        o_dq_oe_n,
   output logic [BA_W-1:0]             o_array_rd_bank,
   output logic [COL_W-1:0]            o_array_rd_col,
   output logic                        o_array_wr_valid,
   output sdram_ctl_pkg::wr_word_t     o_array_wr,
   output logic                        o_wr_overflow,
   output pwr_state_t                  o_pwr_state,
   output logic [NBANK-1:0]            o_bank_idle,
   output logic                        o_deep_pd
);
   pwr_state_t        pwr_reg, pwr_next;
   logic              cke_prev_reg;
   logic [BANK_CNT_W-1:0] pcnt_reg, pcnt_next;

   logic              burst_on_reg;
   logic              burst_wr_reg;
   logic [BA_W-1:0]   burst_bank_reg;
   logic [COL_W-1:0]  col_reg;
   logic [BL_W-1:0]   left_reg;

   // read data pipeline: one slot per latency stage
   logic [3:0]        rd_pipe_v_reg;
   logic [3:0][DQ_W-1:0] rd_pipe_d_reg;
   logic [DQ_W-1:0]   dq_reg;
   logic              dq_oe_n_reg;
   logic              ovf_reg;

   bank_state_t       bank_st [NBANK];
   logic [NBANK-1:0]  bank_idle;

   cmd_kind_t kind;
   assign kind = decode_cmd(i_cmd);

   wire all_idle   = &bank_idle;
   wire is_nop     = (kind == CMD_NOP) || (kind == CMD_INHIBIT);
   wire is_refresh = (kind == CMD_REF_OR_LMR) && i_cmd.we_n;
   wire is_lmr     = (kind == CMD_REF_OR_LMR) && !i_cmd.we_n;
   wire cke_fall   = cke_prev_reg && !i_cke;
   wire cke_rise   = !cke_prev_reg && i_cke;
   // internal clock runs only in normal operation with cke held high
   wire tick       = (pwr_reg == PW_RUN) && cke_prev_reg && i_cke;
   wire is_rd      = tick && (kind == CMD_READ);
   wire is_wr      = tick && (kind == CMD_WRITE);
   wire new_burst  = is_rd || is_wr;
   wire bst        = tick && (kind == CMD_BST);
   wire ap_flag    = i_cmd.addr[AP_BIT];
   wire burst_done = burst_on_reg && (left_reg == BL_ONE);
   wire burst_step = burst_on_reg && tick;
   // a new burst or terminate ends the running one
   wire cut_burst  = burst_on_reg && (new_burst || bst);
   wire end_burst  = cut_burst || (burst_step && burst_done);

   // write data capture; data with the interrupting command belongs to it
   wire wr_cap     = burst_step && burst_wr_reg && !bst && !i_dqm[0] && !cut_burst;
   wire wr_first   = is_wr && !i_dqm[0];
   wire fifo_ready;
   wire push       = wr_cap || wr_first;
   wr_word_t wr_word;
   assign wr_word.data = i_dq;
   assign wr_word.bank = is_wr ? i_cmd.ba : burst_bank_reg;
   assign wr_word.col  = is_wr ? i_cmd.addr[COL_W-1:0] : col_reg;

   sdram_wr_fifo #(
      .WIDTH($bits(wr_word_t)),
      .DEPTH(4)
   ) u_wr_fifo (
      .i_core_clk (i_core_clk),
      .i_resetn   (i_resetn),
      .i_in_valid (push),
      .o_in_ready (fifo_ready),
      .i_in_data  (wr_word),
      .o_out_valid(o_array_wr_valid),
      .i_out_ready(i_array_wr_ready),
      .o_out_data (o_array_wr)
   );

   genvar b;
   generate
      for (b = 0; b < NBANK; b++) begin : g_bank
         wire hit     = (i_cmd.ba == BA_W'(b));
         wire mine    = burst_on_reg && (burst_bank_reg == BA_W'(b));
         wire pre_b   = tick && (kind == CMD_PRE) && (i_cmd.addr[AP_BIT] || hit);
         sdram_bank_fsm u_bank (
            .i_core_clk       (i_core_clk),
            .i_resetn         (i_resetn),
            .i_tick           (tick),
            .i_act            (tick && (kind == CMD_ACT) && hit),
            .i_pre            (pre_b),
            .i_burst_start    (new_burst && hit),
            .i_burst_ap       (ap_flag),
            .i_burst_end      (mine && end_burst && !(new_burst && hit)),
            .i_burst_was_write(burst_wr_reg),
            .o_state          (bank_st[b]),
            .o_idle           (bank_idle[b])
         );
      end
   endgenerate

   // power and clock-enable states
   always_comb begin
      pwr_next  = pwr_reg;
      pcnt_next = (pcnt_reg != '0) ? pcnt_reg - CNT_ONE : pcnt_reg;
      case (pwr_reg)
         PW_RUN: begin
            if (cke_fall && kind == CMD_BST) begin
               pwr_next = PW_DEEP;
            end else if (cke_fall && all_idle && is_nop) begin
               pwr_next = PW_PDOWN;
            end else if (cke_fall && all_idle && is_refresh) begin
               pwr_next = PW_SELFREF;
            end else if (cke_fall && burst_on_reg) begin
               pwr_next = PW_SUSPEND;
            end else if (tick && all_idle && is_refresh) begin
               pwr_next  = PW_BUSY;
               pcnt_next = RC_CYC;
            end else if (tick && all_idle && is_lmr) begin
               pwr_next  = PW_BUSY;
               pcnt_next = MRD_CYC;
            end
         end
         PW_PDOWN:   if (cke_rise && is_nop) pwr_next = PW_RUN;
         PW_SUSPEND: if (cke_rise) pwr_next = PW_RUN;
         PW_SELFREF: if (cke_rise && is_nop) begin
            pwr_next  = PW_XSR;
            pcnt_next = XSR_CYC;
         end
         PW_XSR, PW_BUSY: if (pcnt_reg <= CNT_ONE) pwr_next = PW_RUN;
         PW_DEEP:    if (cke_rise) pwr_next = PW_RUN;
         default:    pwr_next = PW_RUN;
      endcase
   end

   // read data: source column captured at command, delivered CL later
   wire [CL_W-1:0] cl_eff = (i_cas_latency == '0) ? CL_ONE : i_cas_latency;
   wire rd_issue = (burst_step && !burst_wr_reg && !cut_burst && !bst) || is_rd;
   wire [3:0] pipe_next = {rd_pipe_v_reg[2:0], rd_issue};
   wire rd_out_v = rd_pipe_v_reg[cl_eff - CL_ONE];
   assign o_array_rd_bank = is_rd ? i_cmd.ba : burst_bank_reg;
   assign o_array_rd_col  = is_rd ? i_cmd.addr[COL_W-1:0] : col_reg;

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         pwr_reg      <= PW_RUN;
         pcnt_reg     <= '0;
         cke_prev_reg <= 1'b0;
      end else begin
         pwr_reg      <= pwr_next;
         pcnt_reg     <= pcnt_next;
         cke_prev_reg <= i_cke;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         burst_on_reg   <= 1'b0;
         burst_wr_reg   <= 1'b0;
         burst_bank_reg <= '0;
         col_reg        <= '0;
         left_reg       <= '0;
      end else if (new_burst) begin
         burst_on_reg   <= (i_burst_len != BL_ONE);
         burst_wr_reg   <= is_wr;
         burst_bank_reg <= i_cmd.ba;
         col_reg        <= i_cmd.addr[COL_W-1:0] + COL_W'(1);
         left_reg       <= i_burst_len - BL_ONE;
      end else if (end_burst) begin
         burst_on_reg   <= 1'b0;
      end else if (burst_step) begin
         col_reg        <= col_reg + COL_W'(1);
         left_reg       <= left_reg - BL_ONE;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rd_pipe_v_reg <= '0;
         rd_pipe_d_reg <= '0;
         dq_reg        <= '0;
         dq_oe_n_reg   <= 1'b1;
         ovf_reg       <= 1'b0;
      end else begin
         // held during suspend so read data stays driven
         if (pwr_reg != PW_SUSPEND) begin
            rd_pipe_v_reg <= is_wr ? '0 : pipe_next;
            rd_pipe_d_reg <= {rd_pipe_d_reg[2:0], i_array_rdata};
         end
         // word travels with its valid bit, so it leaves at the latency of its column
         dq_reg      <= rd_pipe_d_reg[cl_eff - CL_ONE];
         dq_oe_n_reg <= !(rd_out_v && !is_wr && !i_dqm[0]);
         ovf_reg     <= ovf_reg || (push && !fifo_ready);
      end
   end

   assign o_dq          = dq_reg;
   assign o_dq_oe_n     = dq_oe_n_reg;
   assign o_wr_overflow = ovf_reg;
   assign o_pwr_state   = pwr_reg;
   assign o_bank_idle   = bank_idle;
   assign o_deep_pd     = (pwr_reg == PW_DEEP);
endmodule // sdram_bank_state_cke_control

// ===== hdl/sdram_ctl_pkg.sv
// package for the sdram bank state and clock-enable control block
// assumes one core clock at 20 MHz and pins synchronous to it
package sdram_ctl_pkg;
   localparam int CLK_NS        = 50;
   localparam int NBANK         = 4;
   localparam int BA_W          = 2;
   localparam int DQ_W          = 16;
   localparam int COL_W         = 9;
   localparam int BL_W          = 4;
   localparam int CL_W          = 2;
   localparam int BANK_CNT_W    = 4;
   localparam int AP_BIT        = 10;

   localparam int T_RP_NS       = 18;
   localparam int T_RCD_NS      = 18;
   localparam int T_WR_NS       = 12;
   localparam int T_RC_NS       = 60;
   localparam int T_MRD_NS      = 100;
   localparam int T_XSR_NS      = 120;
   localparam int DPD_MIN_US    = 100;

   function automatic int ceil_cyc(input int ns);
      int c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction

   localparam logic [BANK_CNT_W-1:0] RP_CYC  = BANK_CNT_W'(ceil_cyc(T_RP_NS));
   localparam logic [BANK_CNT_W-1:0] RCD_CYC = BANK_CNT_W'(ceil_cyc(T_RCD_NS));
   localparam logic [BANK_CNT_W-1:0] WR_CYC  = BANK_CNT_W'(ceil_cyc(T_WR_NS));
   localparam logic [BANK_CNT_W-1:0] RC_CYC  = BANK_CNT_W'(ceil_cyc(T_RC_NS));
   localparam logic [BANK_CNT_W-1:0] MRD_CYC = BANK_CNT_W'(ceil_cyc(T_MRD_NS));
   localparam logic [BANK_CNT_W-1:0] XSR_CYC = BANK_CNT_W'(ceil_cyc(T_XSR_NS));
   localparam int DPD_MIN_CYC = (DPD_MIN_US * 1000) / CLK_NS;
   localparam logic [BL_W-1:0] BL_ONE        = 4'h1;
   localparam logic [BANK_CNT_W-1:0] CNT_ONE = 4'h1;
   localparam logic [CL_W-1:0] CL_ONE        = 2'h1;

   typedef enum logic [2:0] {
      CMD_INHIBIT, CMD_NOP, CMD_ACT, CMD_READ, CMD_WRITE,
      CMD_BST, CMD_PRE, CMD_REF_OR_LMR
   } cmd_kind_t;

   typedef enum logic [2:0] {
      BK_IDLE      = 3'b000,
      BK_ACTIVATING= 3'b001,
      BK_ACTIVE    = 3'b011,
      BK_BURST     = 3'b010,
      BK_RECOVER   = 3'b110,
      BK_PRECHARGE = 3'b100
   } bank_state_t;

   // device power state, gray along idle -> pd/sr/deep paths
   typedef enum logic [2:0] {
      PW_RUN     = 3'b000,
      PW_PDOWN   = 3'b001,
      PW_SUSPEND = 3'b011,
      PW_SELFREF = 3'b010,
      PW_XSR     = 3'b110,
      PW_DEEP    = 3'b100,
      PW_BUSY    = 3'b101
   } pwr_state_t;

   typedef struct packed {
      logic            cs_n;
      logic            ras_n;
      logic            cas_n;
      logic            we_n;
      logic [BA_W-1:0] ba;
      logic [12:0]     addr;
   } cmd_pins_t;

   typedef struct packed {
      logic [DQ_W-1:0]  data;
      logic [BA_W-1:0]  bank;
      logic [COL_W-1:0] col;
   } wr_word_t;

   function automatic cmd_kind_t decode_cmd(input cmd_pins_t p);
      if (p.cs_n) return CMD_INHIBIT;
      case ({p.ras_n, p.cas_n, p.we_n})
         3'b111:  return CMD_NOP;
         3'b011:  return CMD_ACT;
         3'b101:  return CMD_READ;
         3'b100:  return CMD_WRITE;
         3'b110:  return CMD_BST;
         3'b010:  return CMD_PRE;
         default: return CMD_REF_OR_LMR;
      endcase
   endfunction
endpackage

// ===== hdl/sdram_wr_fifo.sv
// small fifo for write words heading to the array
// assumes a single clock; drain side may stall
module sdram_wr_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input  wire logic             i_core_clk,
   input  wire logic             i_resetn,
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_out_valid,
   input  wire logic             i_out_ready,
   output logic [WIDTH-1:0]      o_out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      count_reg;
   wire              push = i_in_valid && o_in_ready;
   wire              pop  = o_out_valid && i_out_ready;

   assign o_in_ready  = (count_reg != (AW+1)'(DEPTH));
   assign o_out_valid = (count_reg != '0);
   assign o_out_data  = mem[rd_ptr_reg];

   always_ff @(posedge i_core_clk) begin
      if (push) mem[wr_ptr_reg] <= i_in_data;
   end

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         if (push) wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
         if (pop)  rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
         count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // sdram_wr_fifo

// ===== verification/ctl_model.sv
// controller-side model: command pins, clock enable, mask and write data
// assumes the bench calls its tasks; pins change at the falling edge
module ctl_model
   import sdram_ctl_pkg::*;
(
   input  wire logic                i_core_clk,
   output sdram_ctl_pkg::cmd_pins_t o_cmd,
   output logic                     o_cke,
   output logic [1:0]               o_dqm,
   output logic [DQ_W-1:0]          o_dq
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      o_cmd = {4'hf, 15'h0};
      o_cke = 1'b1;
      o_dqm = 2'h0;
      o_dq  = 16'h0;
   end
   task automatic send(input logic [3:0] k, input logic [1:0] ba, input logic [12:0] a,
                       input logic ck, input logic [DQ_W-1:0] d);
      @(negedge i_core_clk);
      o_cmd = {k, ba, a};
      o_cke = ck;
      o_dq  = d;
   endtask
   // idle cycles; released data line flips every cycle
   task automatic nops(input int n, input logic ck);
      repeat (n) send(4'h7, 2'h0, 13'h0, ck, ~o_dq);
   endtask
   task automatic mask(input logic m);
      o_dqm = {m, m};
   endtask
   task automatic wake_deep();
      nops(DPD_MIN_CYC, 1'b0);
      nops(2 * DPD_MIN_CYC, 1'b1);
      send(4'h2, 2'h0, 13'h400, 1'b1, ~o_dq);
      nops(2, 1'b1);
      repeat (2) begin
         send(4'h1, 2'h0, 13'h0, 1'b1, ~o_dq);
         nops(3, 1'b1);
      end
      send(4'h0, 2'h0, 13'h0, 1'b1, ~o_dq);
      nops(3, 1'b1);
      send(4'h0, 2'h2, 13'h0, 1'b1, ~o_dq);
      nops(3, 1'b1);
   endtask
endmodule // ctl_model

// ===== verification/sdram_bank_state_cke_control_bench.sv
// self-checking bench for the bank state and clock-enable control block
// assumes the controller model; the array returns {bank, 0, column}
module sdram_bank_state_cke_control_bench
   import sdram_ctl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [3:0] NOP = 4'h7, ACT = 4'h3, RD = 4'h5, WR = 4'h4;
   localparam logic [3:0] BST = 4'h6, PRE = 4'h2, REF = 4'h1;
   logic             clk, rstn, rdy, ign, cke, oe_n, wv, ovf, deep;
   logic [CL_W-1:0]  cl;
   logic [BL_W-1:0]  bl;
   cmd_pins_t        cmd;
   logic [1:0]       dqm;
   logic [DQ_W-1:0]  dq, rdq, rdata, d;
   logic [BA_W-1:0]  rb;
   logic [COL_W-1:0] rc;
   wr_word_t         ww;
   pwr_state_t       pwr;
   logic [NBANK-1:0] idle;
   logic [15:0]      rd_q[$];
   wr_word_t         wr_q[$];
   int               n_errors = 0;
   int               samples_checked = 0;
   assign rdata = {rb, 5'h0, rc};
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   ctl_model ctl_model_inst (.i_core_clk(clk), .o_cmd(cmd), .o_cke(cke), .o_dqm(dqm), .o_dq(dq));
   sdram_bank_state_cke_control sdram_bank_state_cke_control_inst (
      .i_core_clk(clk), .i_resetn(rstn), .i_cke(cke), .i_cmd(cmd), .i_dqm(dqm), .i_dq(dq),
      .i_cas_latency(cl), .i_burst_len(bl), .i_array_rdata(rdata), .i_array_wr_ready(rdy),
      .o_dq(rdq), .o_dq_oe_n(oe_n), .o_array_rd_bank(rb), .o_array_rd_col(rc),
      .o_array_wr_valid(wv), .o_array_wr(ww), .o_wr_overflow(ovf), .o_pwr_state(pwr),
      .o_bank_idle(idle), .o_deep_pd(deep));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // drain stalls at random but never two cycles running, so six back-to-back words fit
   always @(negedge clk) rdy <= (rdy !== 1'b1) || (($urandom() & 3) != 0);
   always @(negedge clk)
      if (oe_n === 1'b0 && !ign)
         chk(32'(rdq), rd_q.size() != 0 ? 32'(rd_q.pop_front()) : 32'hx);
   always @(posedge clk)
      if (wv === 1'b1 && rdy === 1'b1 && !ign)
         chk(32'(ww), wr_q.size() != 0 ? 32'(wr_q.pop_front()) : 32'hx);
   function automatic logic [15:0] rx(input int b, input int c);
      return {2'(b), 5'h0, 9'(c)};
   endfunction
   task automatic go(input logic [3:0] k, input int b, input logic [12:0] a, input logic [15:0] v);
      ctl_model_inst.send(k, 2'(b), a, 1'b1, v);
   endtask
   task automatic nop(input int n);
      ctl_model_inst.nops(n, 1'b1);
   endtask
   task automatic wait_idle(input int b);
      for (int i = 0; i < 30 && idle[b] !== 1'b1; i++) nop(1);
      chk(32'(idle[b]), 32'h1);
   endtask
   task automatic pw(input logic [3:0] k, input logic ck, input pwr_state_t s);
      ctl_model_inst.send(k, 2'h0, 13'h0, ck, 16'h0);
      @(posedge clk);
      #1 chk(32'(pwr), 32'(s));
   endtask
   task automatic open2(input int a, input int b);
      go(ACT, a, 0, 0);
      go(ACT, b, 0, 0);
      nop(1);
   endtask
   task automatic done(input string name);
      nop(12);
      chk(32'(rd_q.size() + wr_q.size()), 32'h0);
      chk(32'(ovf), 32'h0);
      $display("test %s done", name);
   endtask
   initial begin
      repeat (100000) @(posedge clk);
      n_errors++;
      print_verdict();
   end
   initial begin
      rstn = 1'b0;
      ign = 1'b0;
      cl = 2'h2;
      bl = 4'h4;
      void'($urandom(36));
      repeat (6) @(negedge clk);
      rstn = 1'b1;
      chk(32'(oe_n), 32'h1);
      chk(32'(idle), 32'hf);
      nop(2);
      open2(0, 1);
      go(PRE, 2, 0, 0);
      nop(1);
      chk(32'(idle), 32'hc);
      // read with auto precharge cut by a read to another bank
      rd_q.push_back(rx(0, 4));
      for (int i = 0; i < 4; i++) rd_q.push_back(rx(1, 8 + i));
      go(RD, 0, 13'h404, 0);
      go(RD, 1, 13'h008, 0);
      nop(3);
      chk(32'(idle[0]), 32'h1);
      done("read_cut_read");
      go(PRE, 1, 0, 0);
      wait_idle(1);
      // read with auto precharge cut by a write, data masked ahead
      bl = 4'h2;
      open2(0, 1);
      ctl_model_inst.mask(1'b1);
      nop(1);
      go(RD, 0, 13'h400, 0);
      ctl_model_inst.mask(1'b0);
      d = 16'($urandom());
      wr_q.push_back({d, 2'h1, 9'h0});
      wr_q.push_back({~d, 2'h1, 9'h1});
      go(WR, 1, 0, d);
      go(NOP, 0, 0, ~d);
      nop(2);
      chk(32'(idle[0]), 32'h1);
      done("read_cut_write");
      go(PRE, 1, 0, 0);
      wait_idle(1);
      // write with auto precharge cut by a read, then by a write
      bl = 4'h4;
      for (int m = 0; m < 2; m++) begin
         open2(2, 3);
         d = 16'($urandom());
         wr_q.push_back({d, 2'h2, 9'h0});
         wr_q.push_back({d + 16'h1, 2'h2, 9'h1});
         go(WR, 2, 13'h400, d);
         go(NOP, 0, 0, d + 16'h1);
         for (int i = 0; i < 4; i++)
            if (m == 0) rd_q.push_back(rx(3, i));
            else wr_q.push_back({d + 16'(i + 2), 2'h3, 9'(i)});
         go(m == 0 ? RD : WR, 3, 0, d + 16'h2);
         for (int i = 3; i < 6; i++) go(NOP, 0, 0, d + 16'(i));
         wait_idle(2);
         done(m == 0 ? "write_cut_read" : "write_cut_write");
         go(PRE, 3, 0, 0);
         wait_idle(3);
      end
      // terminate addressed to another bank ends the newest burst
      bl = 4'h8;
      open2(0, 1);
      d = 16'($urandom());
      wr_q.push_back({d, 2'h0, 9'h0});
      wr_q.push_back({~d, 2'h0, 9'h1});
      go(WR, 0, 0, d);
      go(NOP, 0, 0, ~d);
      go(BST, 1, 0, d ^ 16'h00ff);
      done("terminate");
      go(PRE, 0, 13'h400, 0);
      wait_idle(0);
      wait_idle(1);
      // clock enable: power down, self refresh, suspend, deep
      pw(NOP, 1'b0, PW_PDOWN);
      pw(NOP, 1'b1, PW_RUN);
      pw(REF, 1'b0, PW_SELFREF);
      pw(NOP, 1'b0, PW_SELFREF);
      nop(2);
      for (int i = 0; i < 10 && pwr !== PW_RUN; i++) nop(1);
      chk(32'(pwr), 32'(PW_RUN));
      go(ACT, 0, 0, 0);
      nop(1);
      ign = 1'b1;
      go(WR, 0, 0, 0);
      pw(NOP, 1'b0, PW_SUSPEND);
      pw(NOP, 1'b1, PW_RUN);
      go(BST, 0, 0, 0);
      nop(12);
      wr_q.delete();
      ign = 1'b0;
      go(PRE, 0, 0, 0);
      wait_idle(0);
      pw(BST, 1'b0, PW_DEEP);
      chk(32'(deep), 32'h1);
      ctl_model_inst.wake_deep();
      chk(32'(deep), 32'h0);
      chk(32'(pwr), 32'(PW_RUN));
      done("power");
      print_verdict();
   end
endmodule // sdram_bank_state_cke_control_bench

// ===== verification/sdram_bank_state_cke_control_chk.sv
// checker for the bank state and clock-enable control block
// sees only the top ports; bound to the top at the end of this file
module sdram_bank_state_cke_control_chk
   import sdram_ctl_pkg::*;
(
   input  wire logic                i_core_clk,
   input  wire logic                i_resetn,
   input  wire logic                i_cke,
   input  sdram_ctl_pkg::cmd_pins_t i_cmd,
   input  wire logic [1:0]          i_dqm,
   input  wire logic [CL_W-1:0]     i_cas_latency,
   input  wire logic                o_dq_oe_n,
   input  sdram_ctl_pkg::pwr_state_t o_pwr_state,
   input  wire logic [NBANK-1:0]    o_bank_idle,
   input  wire logic                o_deep_pd
);
   timeunit 1ns;
   timeprecision 1ns;
   logic       cke_q;
   logic [3:0] k;
   logic       run;
   logic       tk;
   logic       calm;
   logic       xsr;
   // matches the design's cke history, which resets low
   always_ff @(posedge i_core_clk or negedge i_resetn)
      if (!i_resetn) cke_q <= 1'b0;
      else cke_q <= i_cke;
   assign k    = {i_cmd.cs_n, i_cmd.ras_n, i_cmd.cas_n, i_cmd.we_n};
   assign run  = o_pwr_state == PW_RUN && cke_q;
   assign tk   = run && i_cke;
   assign calm = i_cke && !i_dqm[0] && k != 4'h4 && k != 4'h6;
   assign xsr  = o_pwr_state == PW_XSR;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_resetn);
   a_deep_entry: assert property (run && !i_cke && k == 4'h6 |=> o_deep_pd)
      else $error("deep power down not entered");
   a_pdown_entry: assert property (run && !i_cke && (k == 4'h7 || k[3]) && &o_bank_idle
      |=> o_pwr_state == PW_PDOWN) else $error("power down not entered");
   a_selfref_entry: assert property (run && !i_cke && k == 4'h1 && &o_bank_idle
      |=> o_pwr_state == PW_SELFREF) else $error("self refresh not entered");
   a_pdown_exit: assert property (o_pwr_state == PW_PDOWN && i_cke
      |=> o_pwr_state == PW_RUN) else $error("power down exit late");
   a_xsr_wait: assert property ($rose(xsr) |=> xsr ##[1:4] o_pwr_state == PW_RUN)
      else $error("self refresh exit time wrong");
   a_suspend_exit: assert property (o_pwr_state == PW_SUSPEND && i_cke
      |=> o_pwr_state == PW_RUN) else $error("suspend exit late");
   a_read_latency: assert property (tk && k == 4'h5 && i_cas_latency == 2'h2
      ##1 calm [*2] |=> !o_dq_oe_n) else $error("read data not at cas latency");
   a_pre_noop: assert property (tk && k == 4'h2 && !i_cmd.addr[10] && o_bank_idle[i_cmd.ba]
      |=> o_bank_idle[$past(i_cmd.ba)]) else $error("precharge disturbed idle bank");
   a_act_leaves: assert property (tk && k == 4'h3 && o_bank_idle[i_cmd.ba]
      |=> !o_bank_idle[$past(i_cmd.ba)]) else $error("activate not decoded");
   c_deep: cover property (o_deep_pd);
   c_suspend: cover property (o_pwr_state == PW_SUSPEND);
   c_read: cover property (!o_dq_oe_n);
endmodule // sdram_bank_state_cke_control_chk

bind sdram_bank_state_cke_control sdram_bank_state_cke_control_chk chk_inst (
   .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_cke(i_cke), .i_cmd(i_cmd), .i_dqm(i_dqm),
   .i_cas_latency(i_cas_latency), .o_dq_oe_n(o_dq_oe_n), .o_pwr_state(o_pwr_state),
   .o_bank_idle(o_bank_idle), .o_deep_pd(o_deep_pd));
